// ### core/tps_pkg.sv
package tps_pkg;
  // register bus geometry
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_COUNT = 8'h01;
  localparam logic [IDX_W-1:0] IDX_INTCTL = 8'h0b;
  localparam logic [IDX_W-1:0] IDX_OPTION = 8'h81;
  localparam logic [IDX_W-1:0] IDX_ISTAT = 8'h90;
  localparam logic [IDX_W-1:0] IDX_ICLR = 8'h91;
  localparam logic [IDX_W-1:0] IDX_IEN = 8'h92;

  // reset values
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // option_config fields
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int RATE_W = 3;

  // interrupt_control fields
  localparam int INT_IEN_BIT = 5;
  localparam int INT_FLAG_BIT = 2;
  localparam int IRQ_BIT = 0;

  // instruction cycle phases
  localparam logic [1:0] PH_SECOND = 2'h1;
  localparam logic [1:0] PH_FOURTH = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### core/tps_psc_if.sv
`timescale 1ns/1ns
`default_nettype none
// links the timer core to the shared prescaler
interface tps_psc_if;
  logic t0_tick;            // one source event for the counter path
  logic wdt_tick;           // one watchdog oscillator event
  logic clear;              // clear the prescaler count
  logic assign_wdt;         // prescaler serves the watchdog
  logic [2:0] rate;         // division select
  logic t0_level;           // divided level for the counter path
  logic wdt_pulse;          // postscaled watchdog event
  modport presc (input t0_tick, wdt_tick, clear, assign_wdt, rate,
                 output t0_level, wdt_pulse);
  modport ctrl (output t0_tick, wdt_tick, clear, assign_wdt, rate,
                input t0_level, wdt_pulse);
endinterface
`default_nettype wire

// ### core/tps_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module tps_prescaler
  import tps_pkg::*;
#(
  parameter int PSC_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  tps_psc_if.presc p
);
  logic [PSC_W-1:0] cnt_reg;      // hidden prescaler count
  logic [PSC_W-1:0] low_mask;     // bits that must be all ones for a wdt pulse
  logic tick;                     // event for whichever user owns it
  logic wdt_pulse_reg;

  // one counter, one owner at a time
  assign tick = p.assign_wdt ? p.wdt_tick : p.t0_tick;
  assign low_mask = PSC_W'((PSC_W'(1) << p.rate) - PSC_W'(1));

  ////////////////////////////////////////////////////////////////////
  // count; a clear wins over a tick in the same cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else if (p.clear) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + PSC_W'(1);
    end
  end

  // bit rate toggles every 2^rate events: period 2^(rate+1)
  assign p.t0_level = cnt_reg[p.rate];

  // watchdog postscaler: 1:2^rate, or undivided when not assigned
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_pulse_reg <= 1'b0;
    end else if (!p.assign_wdt) begin
      wdt_pulse_reg <= p.wdt_tick;
    end else begin
      wdt_pulse_reg <= p.wdt_tick && !p.clear && ((cnt_reg & low_mask) == low_mask);
    end
  end
  assign p.wdt_pulse = wdt_pulse_reg;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  AST_WDT_CLEAR: assert property (p.assign_wdt && p.clear |=> cnt_reg == '0)
    else $error("prescaler not cleared by watchdog clear");
  AST_WDT_DIV1: assert property (p.assign_wdt && p.rate == 3'h0 && p.wdt_tick && !p.clear
                                 |=> p.wdt_pulse)
    else $error("watchdog rate zero must pass every event");
endmodule
`default_nettype wire

// ### core/tps_timer0.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Function
// - timer mode counts every instruction cycle when prescaler unassigned
// - counter write blocks two following cycles
// - source select set counts pin edges
// - edge select: zero rising, one falling
// - wrap from maximum sets overflow flag
// - interrupt only while enable bit set
// - flag sticky until software clears it
// - counter halted during sleep
// - prescaler output sampled on phases two, four
// - unassigned prescaler: pin feeds sampler directly
// - one prescaler shared with the watchdog
// - rate field: counter 2^(n+1), watchdog 2^n
// - eight bit counter, software read and write
// - assign bit: zero counter, one watchdog
// - counter write clears prescaler when assigned
// - watchdog clear clears prescaler when assigned
module tps_timer0
  import tps_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [AXI_DW/8-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // counter pin and core-side events
  input wire logic ext_count_clock_i,
  input wire logic sleep_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic wdt_osc_tick_i,
  output logic wdt_postscale_o,
  output logic irq_o
);
  // byte address to register index, any upper bits make it unmapped
  function automatic logic [IDX_W-1:0] reg_index(input logic [AXI_AW-1:0] a);
    reg_index = a[IDX_LSB +: IDX_W];
  endfunction
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    logic [IDX_W-1:0] i;
    i = a[IDX_LSB +: IDX_W];
    is_mapped = (a[AXI_AW-1:IDX_LSB+IDX_W] == '0) &&
                (i == IDX_COUNT || i == IDX_INTCTL || i == IDX_OPTION ||
                 i == IDX_ISTAT || i == IDX_ICLR || i == IDX_IEN);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // declarations
  tps_psc_if psc ();                    // link to the shared prescaler
  logic [7:0] count_reg;                // count_value
  logic [7:0] intctl_reg;               // interrupt_control
  logic [7:0] option_reg;               // option_config
  logic [1:0] inhibit_reg;              // cycles left with counting blocked
  logic [1:0] phase_reg;                // four phases per instruction cycle
  logic ext_meta_reg;                   // pin synchroniser, first stage
  logic ext_sync_reg;                   // pin synchroniser, second stage
  logic edge_lvl_d_reg;                 // delayed edge-adjusted pin level
  logic samp_reg;                       // phase-sampled prescaler output
  logic samp_d_reg;                     // previous sample
  logic irq_reg;
  // bus
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [AXI_DW-1:0] rdata_reg;
  // decoded
  logic wr_go, wr_ok;
  logic [IDX_W-1:0] widx;
  logic count_wr, intctl_wr, option_wr, iclr_wr, ien_wr;
  logic src_ext, edge_fall, assign_wdt;  // option fields
  logic edge_lvl, ext_edge, cycle_end, sample_now, samp_rise;
  logic inc_ev, inc, overflow, flag, irq_en;

  ////////////////////////////////////////////////////////////////////
  // option fields
  assign src_ext = option_reg[OPT_SRC_BIT];
  assign edge_fall = option_reg[OPT_EDGE_BIT];
  assign assign_wdt = option_reg[OPT_ASSIGN_BIT];
  assign flag = intctl_reg[INT_FLAG_BIT];
  assign irq_en = intctl_reg[INT_IEN_BIT];

  ////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      awready_reg <= 1'b1;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid_i && awready_reg) begin
      awready_reg <= 1'b0;
      awaddr_reg <= s_axi_awaddr_i;
    end else if (bvalid_reg && s_axi_bready_i) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wready_reg <= 1'b1;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid_i && wready_reg) begin
      wready_reg <= 1'b0;
      wdata_reg <= s_axi_wdata_i[7:0];  // registers live in the low lane
      wstrb0_reg <= s_axi_wstrb_i[0];
    end else if (bvalid_reg && s_axi_bready_i) begin
      wready_reg <= 1'b1;
    end
  end

  // both halves held and no response pending: commit once
  assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_ok = wr_go && is_mapped(awaddr_reg) && wstrb0_reg;
  assign widx = reg_index(awaddr_reg);
  assign count_wr = wr_ok && widx == IDX_COUNT;
  assign intctl_wr = wr_ok && widx == IDX_INTCTL;
  assign option_wr = wr_ok && widx == IDX_OPTION;
  assign iclr_wr = wr_ok && widx == IDX_ICLR;
  assign ien_wr = wr_ok && widx == IDX_IEN;

  // write response
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel: data registered one edge after the address
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= '0;
      if (is_mapped(s_axi_araddr_i)) begin
        case (reg_index(s_axi_araddr_i))
          IDX_COUNT: rdata_reg[7:0] <= count_reg;
          IDX_INTCTL: rdata_reg[7:0] <= intctl_reg;
          IDX_OPTION: rdata_reg[7:0] <= option_reg;
          IDX_ISTAT: rdata_reg[IRQ_BIT] <= flag;
          IDX_IEN: rdata_reg[IRQ_BIT] <= irq_en;
          default: rdata_reg <= '0;  // clear register reads as zero
        endcase
      end
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      option_reg <= OPTION_RST;
    end else if (option_wr) begin
      option_reg <= wdata_reg;
    end
  end

  // interrupt control; the overflow set is last so it beats any clear
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      intctl_reg <= INTCTL_RST;
    end else begin
      if (intctl_wr) begin
        intctl_reg <= wdata_reg;
      end
      if (ien_wr) begin
        intctl_reg[INT_IEN_BIT] <= wdata_reg[IRQ_BIT];
      end
      if (iclr_wr && wdata_reg[IRQ_BIT]) begin
        intctl_reg[INT_FLAG_BIT] <= 1'b0;
      end
      if (overflow) begin
        intctl_reg[INT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // level interrupt, masked by the enable bit
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag && irq_en;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // instruction cycle phases; phase 3 closes a cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign cycle_end = phase_reg == PH_FOURTH;
  assign sample_now = phase_reg == PH_SECOND || phase_reg == PH_FOURTH;

  // pin synchroniser; only the second stage is looked at
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_count_clock_i;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // inverting for falling edges turns every wanted edge into a rise
  assign edge_lvl = ext_sync_reg ^ edge_fall;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // idle level of the pin seen through the reset edge select, so no false edge
      edge_lvl_d_reg <= OPTION_RST[OPT_EDGE_BIT];
    end else begin
      edge_lvl_d_reg <= edge_lvl;
    end
  end
  assign ext_edge = edge_lvl && !edge_lvl_d_reg;

  // prescaler hookup; sleep stops its counter path too
  assign psc.t0_tick = !sleep_i && (src_ext ? ext_edge : cycle_end);
  assign psc.wdt_tick = wdt_osc_tick_i;
  assign psc.clear = assign_wdt ? watchdog_clear_instr_i : count_wr;
  assign psc.assign_wdt = assign_wdt;
  assign psc.rate = option_reg[OPT_RATE_LSB +: RATE_W];

  tps_prescaler #(.PSC_W(8)) u_presc (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .p(psc.presc)
  );

  // sample the prescaler output (or the raw pin) on phases two and four;
  // this is why the pin must stay two oscillator periods at each level
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // start at the idle sample, or the first sample would look like a rise
      samp_reg <= OPTION_RST[OPT_EDGE_BIT];
      samp_d_reg <= OPTION_RST[OPT_EDGE_BIT];
    end else begin
      samp_d_reg <= samp_reg;
      if (sample_now) begin
        samp_reg <= assign_wdt ? edge_lvl : psc.t0_level;
      end
    end
  end
  assign samp_rise = samp_reg && !samp_d_reg;

  // increment source: plain cycles only in undivided timer mode
  assign inc_ev = (!src_ext && assign_wdt) ? cycle_end : samp_rise;
  assign inc = inc_ev && !sleep_i && inhibit_reg == '0 && !count_wr;
  assign overflow = inc && count_reg == CNT_MAX;

  // inhibit window after a write, counted in instruction cycles
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inhibit_reg <= '0;
    end else if (count_wr) begin
      inhibit_reg <= INHIBIT_CYCLES;
    end else if (cycle_end && inhibit_reg != '0) begin
      inhibit_reg <= inhibit_reg - 2'h1;
    end
  end

  // the counter itself; a write drops a colliding increment
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= COUNT_RST;
    end else if (count_wr) begin
      count_reg <= wdata_reg;
    end else if (inc) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign wdt_postscale_o = psc.wdt_pulse;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_write;
    count_wr;
  endsequence
  sequence s_quiet;
    !count_wr;
  endsequence

  AST_INHIBIT: assert property (s_write ##1 s_quiet [*4] |-> $stable(count_reg))
    else $error("counter moved during write inhibit");
  AST_TIMER_STEP: assert property (!src_ext && assign_wdt && cycle_end && !sleep_i &&
                                   inhibit_reg == '0 && !count_wr
                                   |=> count_reg == $past(count_reg) + 8'h01)
    else $error("timer mode missed an instruction cycle");
  AST_OVF_FLAG: assert property (inc && count_reg == CNT_MAX |=> flag && count_reg == '0)
    else $error("wrap did not set overflow flag");
  AST_IRQ_MASK: assert property (!irq_en |=> !irq_o)
    else $error("interrupt raised while masked");
  AST_FLAG_STICKY: assert property (flag && !intctl_wr && !iclr_wr |=> flag)
    else $error("overflow flag dropped without software");
  AST_SLEEP: assert property (sleep_i && !count_wr |=> $stable(count_reg))
    else $error("counter moved during sleep");
  AST_SAMPLE_PHASE: assert property ($changed(samp_reg) |-> $past(sample_now))
    else $error("sample taken outside phases two and four");
  AST_WRITE_WINS: assert property (count_wr |=> count_reg == $past(wdata_reg))
    else $error("written value lost");
  AST_T0_CLEAR: assert property (!assign_wdt && count_wr |=> u_presc.cnt_reg == '0)
    else $error("counter write left prescaler count");
endmodule
`default_nettype wire

// ### tb/tps_ext_clk_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: a clock source on the counter pin, still between bursts
module tps_ext_clk_model #(
  parameter int HALF = 8 // mclk per level
) (
  input wire logic mclk_i,
  input wire logic start_i, // pulse: begin a burst
  input wire logic [7:0] toggles_i, // level changes in the burst
  output logic busy_o,
  output logic pin_o
);
  int cnt; // mclk spent in the current level
  logic [7:0] left; // level changes still owed
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    left = 8'h00;
    cnt = 0;
  end
  ////////////////////////////////////////////////////////////////
  // each level held HALF cycles, so the sampler never misses one
  always @(posedge mclk_i) begin
    if (start_i) begin
      left <= toggles_i;
      busy_o <= 1'b1;
      cnt <= 0;
    end else if (busy_o) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1 && left != 8'h00) begin
        pin_o <= ~pin_o;
        left <= left - 8'h01;
      end else if (cnt == HALF - 1) begin
        busy_o <= 1'b0; // last level also held full length
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %0h want %0h", $time, g, e); end end
module tb;
  import tps_pkg::*;
  localparam logic [11:0] A_CNT = {2'b00, IDX_COUNT, 2'b00};
  localparam logic [11:0] A_INT = {2'b00, IDX_INTCTL, 2'b00};
  localparam logic [11:0] A_OPT = {2'b00, IDX_OPTION, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, IDX_ISTAT, 2'b00};
  localparam logic [11:0] A_CLR = {2'b00, IDX_ICLR, 2'b00};
  localparam logic [11:0] A_IEN = {2'b00, IDX_IEN, 2'b00};
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sleep = 1'b0, wclr = 1'b0, wtick = 1'b0, start = 1'b0;
  logic [7:0] toggles = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, wpost, irq, pin, busy;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] c1, c2;
  int n_mismatch = 0;
  int checks = 0;
  int wdt_cnt = 0; // watchdog events seen
  int n0;
  always #20 mclk_i = ~mclk_i;
  // only byte 0 carries data, so the strobe is tied
  tps_timer0 dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ext_count_clock_i(pin), .sleep_i(sleep),
    .watchdog_clear_instr_i(wclr), .wdt_osc_tick_i(wtick), .wdt_postscale_o(wpost),
    .irq_o(irq));
  tps_ext_clk_model #(.HALF(8)) src_u (.mclk_i(mclk_i), .start_i(start),
    .toggles_i(toggles), .busy_o(busy), .pin_o(pin));
  // count postscaled watchdog pulses
  always @(posedge mclk_i) begin
    if (wpost === 1'b1) wdt_cnt <= wdt_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  // bus tasks: each channel dropped only at its own handshake edge
  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 200);
    bready <= 1'b0;
    r = bresp;
    `CHK(bvalid, 1'b1)
    // an edge passes before a following call raises bready again
    @(posedge mclk_i);
  endtask
  task automatic axr(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 200);
    rready <= 1'b0;
    d = rdata[7:0];
    r = rresp;
    `CHK(rdata[31:8], 24'h000000)
    `CHK(rvalid, 1'b1)
    // an edge passes before a following call raises rready again
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    axw(a, d, resp);
    `CHK(resp, RESP_OKAY)
  endtask
  task automatic chkrd(input logic [11:0] a, input logic [7:0] e);
    axr(a, c1, resp);
    `CHK(resp, RESP_OKAY)
    `CHK(c1, e)
  endtask
  // far side burst, then room for sync and sampling latency
  task automatic pulse_pin(input logic [7:0] n);
    int t;
    t = 0;
    toggles <= n;
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    @(posedge mclk_i);
    while (busy && t < 5000) begin
      @(posedge mclk_i);
      t++;
    end
    `CHK(busy, 1'b0)
    repeat (12) @(posedge mclk_i);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      wtick <= 1'b1;
      @(posedge mclk_i);
      wtick <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic wdt_clear();
    wclr <= 1'b1;
    @(posedge mclk_i);
    wclr <= 1'b0;
    @(posedge mclk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chkrd(A_OPT, OPTION_RST);
    chkrd(A_INT, INTCTL_RST);
    chkrd(A_CNT, COUNT_RST);
    axr(12'h100, c2, resp);
    `CHK(resp, RESP_SLVERR)
    `CHK(c2, 8'h00)
    axw(12'h100, 8'h5a, resp);
    `CHK(resp, RESP_SLVERR)
    $display("test reset done");
  endtask
  task automatic t_timer();
    wr(A_OPT, 8'h08);
    wr(A_CNT, 8'h20);
    repeat (20) @(posedge mclk_i);
    axr(A_CNT, c1, resp);
    `CHK(c1 inside {[8'h22:8'h24]}, 1'b1)
    repeat (37) @(posedge mclk_i);
    axr(A_CNT, c2, resp);
    `CHK(c2 - c1, 8'h0a)
    $display("test timer done");
  endtask
  task automatic t_irq();
    wr(A_INT, 8'h20);
    wr(A_CNT, 8'hfe);
    repeat (40) @(posedge mclk_i);
    `CHK(irq, 1'b1)
    chkrd(A_STAT, 8'h01);
    wr(A_INT, 8'h04); // flag kept, enable off
    repeat (3) @(posedge mclk_i);
    `CHK(irq, 1'b0)
    chkrd(A_INT, 8'h04);
    wr(A_IEN, 8'h01);
    repeat (3) @(posedge mclk_i);
    `CHK(irq, 1'b1)
    wr(A_CLR, 8'h01);
    repeat (3) @(posedge mclk_i);
    `CHK(irq, 1'b0)
    chkrd(A_STAT, 8'h00);
    chkrd(A_CLR, 8'h00);
    chkrd(A_INT, 8'h20);
    wr(A_INT, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_sleep();
    sleep <= 1'b1;
    wr(A_CNT, 8'hff);
    repeat (60) @(posedge mclk_i);
    chkrd(A_CNT, 8'hff);
    chkrd(A_STAT, 8'h00);
    sleep <= 1'b0;
    $display("test sleep done");
  endtask
  // every rate: reads 32*div cycles apart see eight counts
  task automatic t_psc();
    for (int r = 0; r < 8; r++) begin
      wr(A_OPT, {5'h00, r[2:0]});
      wr(A_CNT, 8'h00);
      axr(A_CNT, c1, resp);
      repeat (32 * (2 << r) - 3) @(posedge mclk_i);
      axr(A_CNT, c2, resp);
      `CHK((c2 - c1) inside {[8'h07:8'h09]}, 1'b1)
    end
    $display("test prescaler done");
  endtask
  task automatic t_ext();
    for (int e = 0; e < 2; e++) begin
      wr(A_OPT, {3'h1, e[0], 4'h8});
      wr(A_CNT, 8'h00);
      pulse_pin(8'h01);
      chkrd(A_CNT, {7'h00, ~e[0]});
      pulse_pin(8'h01);
      chkrd(A_CNT, 8'h01);
    end
    wr(A_OPT, 8'h28);
    wr(A_CNT, 8'h00);
    pulse_pin(8'h0a);
    chkrd(A_CNT, 8'h05);
    wr(A_OPT, 8'h20);
    wr(A_CNT, 8'h00);
    pulse_pin(8'h10);
    chkrd(A_CNT, 8'h04);
    $display("test pin done");
  endtask
  task automatic t_wdt();
    for (int r = 0; r < 4; r++) begin
      wr(A_OPT, {5'h01, r[2:0]});
      wdt_clear();
      n0 = wdt_cnt;
      ticks(16);
      `CHK(wdt_cnt - n0, 16 >> r)
    end
    wr(A_OPT, 8'h0a);
    wdt_clear();
    ticks(3);
    wdt_clear();
    n0 = wdt_cnt;
    ticks(3);
    `CHK(wdt_cnt - n0, 0)
    wr(A_OPT, 8'h02);
    n0 = wdt_cnt;
    ticks(5);
    `CHK(wdt_cnt - n0, 5)
    $display("test watchdog done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard, well past the ~17k cycles of the sequence
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_timer();
    t_irq();
    t_sleep();
    t_psc();
    t_ext();
    t_wdt();
    give_verdict();
  end
endmodule
`default_nettype wire
